// file: hw/ism_pkg.sv
package ism_pkg;

  localparam int ISM_NSRC = 25;
  localparam int ISM_NSINK = 18;
  localparam int ISM_NLINE = 23;
  localparam int ISM_NOD = 4;
  localparam int ISM_NIN = 5;

  // Select codes above the last source give a constant low
  localparam logic [4:0] ISM_SEL_OFF = 5'h1F;

  localparam logic [7:0] ISM_ROUTE_BASE = 8'h00;
  localparam logic [7:0] ISM_LINE_BASE = 8'h20;
  localparam logic [7:0] ISM_CMD_ADDR = 8'h40;
  localparam logic [7:0] ISM_SRC_STAT_ADDR = 8'h41;
  localparam logic [7:0] ISM_SINK_STAT_ADDR = 8'h42;
  localparam logic [7:0] ISM_PIN_STAT_ADDR = 8'h43;

  localparam int ISM_LINE_INV_BIT = 0;
  localparam int ISM_LINE_FRC_BIT = 1;
  localparam int ISM_CMD_SAVE_BIT = 0;
  localparam int ISM_CMD_LOAD_BIT = 1;
  localparam int ISM_CMD_DEFAULT_BIT = 2;

  localparam logic [4:0] ISM_SRC_PIN0 = 5'h00;
  localparam logic [4:0] ISM_SRC_STROBE0 = 5'h06;
  localparam logic [4:0] ISM_SRC_STROBE1 = 5'h07;
  localparam logic [4:0] ISM_SRC_SEQ_MOD_A = 5'h08;
  localparam logic [4:0] ISM_SRC_SEQ_MOD_B = 5'h09;
  localparam logic [4:0] ISM_SRC_SEQ_PULSE = 5'h0C;
  localparam logic [4:0] ISM_SRC_SEQ_MOD_C = 5'h0D;
  localparam logic [4:0] ISM_SRC_SEQ_MOD_D = 5'h0E;
  localparam logic [4:0] ISM_SRC_SEQ_ACTIVE = 5'h0F;
  localparam logic [4:0] ISM_SRC_DEBOUNCED = 5'h10;
  localparam logic [4:0] ISM_SRC_PRESCALED = 5'h11;
  localparam logic [4:0] ISM_SRC_SEQ_MASK = 5'h12;
  localparam logic [4:0] ISM_SRC_LOGIC = 5'h13;
  localparam logic [4:0] ISM_SRC_STROBE2 = 5'h14;
  localparam logic [4:0] ISM_SRC_STROBE3 = 5'h15;
  localparam logic [4:0] ISM_SRC_UART2_TXD = 5'h18;

  localparam int ISM_SINK_TRIGGER = 6;
  localparam int ISM_SINK_SEQ = 7;
  localparam int ISM_SINK_DEBOUNCE = 8;
  localparam int ISM_SINK_PRESCALE = 9;
  localparam int ISM_SINK_LOGIC_A = 10;
  localparam int ISM_SINK_PULSE0 = 13;
  localparam int ISM_SINK_UART2_RXD = 17;

  // Input lines 10 to 14 condition sources 0 to 4
  localparam int ISM_LINE_INPUT0 = 10;
  localparam logic [4:0] ISM_SINK_LINE [ISM_NSINK] = '{
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};

  typedef struct packed {
    logic [3:0] trig_in;
    logic rxd;
    logic aux_rxd;
  } ism_pin_in_t;

  typedef struct packed {
    logic uart1_txd;
    logic [3:0] strobe;
    logic [3:0] seq_mod;
    logic expose;
    logic readout;
    logic seq_pulse;
    logic seq_active;
    logic debounced;
    logic prescaled;
    logic seq_mask;
    logic logic_res;
    logic trig_feedback;
    logic uart2_txd;
  } ism_int_src_t;

  typedef struct packed {
    logic [ISM_NSINK-1:0][4:0] route;
    logic [ISM_NLINE-1:0] inv;
    logic [ISM_NLINE-1:0] frc;
  } ism_image_t;

  typedef struct packed {
    ism_image_t cfg;
    logic [ISM_NSINK-1:0] sink;
    logic [ISM_NOD-1:0] od_out;
    logic [ISM_NOD-1:0] od_oe;
    logic [31:0] rdata;
    logic save;
    logic load_req;
    ism_image_t nv_wdata;
    logic booted;
  } ism_state_t;

  localparam ism_image_t ISM_IMAGE_DEFAULT = '{
    route: {ISM_NSINK{ISM_SEL_OFF}}, inv: '0, frc: '0};

  localparam ism_state_t ISM_STATE_RESET = '{
    cfg: ISM_IMAGE_DEFAULT, nv_wdata: ISM_IMAGE_DEFAULT, default: '0};

endpackage

// file: hw/ism_sync.sv
module ism_sync
  import ism_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] held;
  } ism_sync_state_t;

  ism_sync_state_t st;
  ism_sync_state_t next_st;

  // The first stage is read only by the second
  always_comb
  begin
    next_st.meta = async_in;
    next_st.held = st.meta;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.held;

endmodule

// file: hw/ism_line_cond.sv
module ism_line_cond
  import ism_pkg::*;
(
  input wire logic sig_in,
  input wire logic invert,
  input wire logic force_high,
  output logic sig_out
);

  // Force sits ahead of the inverter, so force plus invert gives low
  always_comb
  begin
    if (force_high)
    begin
      sig_out = ~invert;
    end
    else
    begin
      sig_out = sig_in ^ invert;
    end
  end

endmodule

// file: hw/ism_switch_matrix.sv
// The register offsets and the address-and-strobe port were left to the implementer.
module ism_switch_matrix
  import ism_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire ism_pin_in_t pin_in,
  input wire logic [ISM_NOD-1:0] od_in,
  input wire ism_int_src_t int_src,
  output logic [ISM_NSINK-1:0] sink_out,
  output logic [ISM_NOD-1:0] od_out,
  output logic [ISM_NOD-1:0] od_oe,
  output logic nv_save,
  output logic nv_load_req,
  output ism_image_t nv_wdata,
  input wire ism_image_t nv_rdata,
  input wire logic nv_rdata_valid
);

  ism_state_t st;
  ism_state_t next_st;

  ism_pin_in_t pin_sync;
  logic [ISM_NOD-1:0] od_sync;
  logic [ISM_NSRC-1:0] src_raw;
  logic [ISM_NSRC-1:0] src_vec;
  logic [ISM_NIN-1:0] src_in_cond;
  logic [ISM_NSINK-1:0] sink_cond;
  logic [4:0] reg_off;
  logic route_hit;
  logic line_hit;

  // Pins and open-drain readback come from outside the clock domain
  ism_sync #(
    .WIDTH(ISM_NOD + $bits(ism_pin_in_t))
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in({od_in, pin_in}),
    .sync_out({od_sync, pin_sync})
  );

  // Source vector; helper module returns are on this clock already
  always_comb
  begin
    src_raw = '0;
    src_raw[ISM_SRC_PIN0 +: 4] = pin_sync.trig_in;
    src_raw[4] = pin_sync.rxd;
    src_raw[5] = int_src.uart1_txd;
    src_raw[ISM_SRC_STROBE0] = int_src.strobe[0];
    src_raw[ISM_SRC_STROBE1] = int_src.strobe[1];
    src_raw[ISM_SRC_SEQ_MOD_A] = int_src.seq_mod[0];
    src_raw[ISM_SRC_SEQ_MOD_B] = int_src.seq_mod[1];
    src_raw[10] = int_src.expose;
    src_raw[11] = int_src.readout;
    src_raw[ISM_SRC_SEQ_PULSE] = int_src.seq_pulse;
    src_raw[ISM_SRC_SEQ_MOD_C] = int_src.seq_mod[2];
    src_raw[ISM_SRC_SEQ_MOD_D] = int_src.seq_mod[3];
    src_raw[ISM_SRC_SEQ_ACTIVE] = int_src.seq_active;
    src_raw[ISM_SRC_DEBOUNCED] = int_src.debounced;
    src_raw[ISM_SRC_PRESCALED] = int_src.prescaled;
    src_raw[ISM_SRC_SEQ_MASK] = int_src.seq_mask;
    src_raw[ISM_SRC_LOGIC] = int_src.logic_res;
    src_raw[ISM_SRC_STROBE2] = int_src.strobe[2];
    src_raw[ISM_SRC_STROBE3] = int_src.strobe[3];
    src_raw[22] = pin_sync.aux_rxd;
    src_raw[23] = int_src.trig_feedback;
    src_raw[ISM_SRC_UART2_TXD] = int_src.uart2_txd;
  end

  // Input lines condition pin sources 0 to 4 before routing
  for (genvar i = 0; i < ISM_NIN; i++)
  begin : g_in_line
    ism_line_cond u_cond (
      .sig_in(src_raw[i]),
      .invert(st.cfg.inv[ISM_LINE_INPUT0 + i]),
      .force_high(st.cfg.frc[ISM_LINE_INPUT0 + i]),
      .sig_out(src_in_cond[i])
    );
  end

  always_comb
  begin
    src_vec = src_raw;
    src_vec[ISM_NIN-1:0] = src_in_cond;
  end

  // One selector per sink; out-of-range codes read as low
  for (genvar k = 0; k < ISM_NSINK; k++)
  begin : g_sink
    logic [4:0] sel;
    logic raw;
    assign sel = st.cfg.route[k];
    assign raw = (sel < 5'(ISM_NSRC)) ? src_vec[sel] : 1'b0;
    ism_line_cond u_cond (
      .sig_in(raw),
      .invert(st.cfg.inv[ISM_SINK_LINE[k]]),
      .force_high(st.cfg.frc[ISM_SINK_LINE[k]]),
      .sig_out(sink_cond[k])
    );
  end

  assign reg_off = reg_addr[4:0];
  assign route_hit = (reg_addr[7:5] == ISM_ROUTE_BASE[7:5])
    && (reg_off < 5'(ISM_NSINK));
  assign line_hit = (reg_addr[7:5] == ISM_LINE_BASE[7:5])
    && (reg_off < 5'(ISM_NLINE));

  always_comb
  begin
    next_st = st;
    next_st.save = 1'b0;
    next_st.load_req = 1'b0;
    next_st.rdata = '0;
    next_st.booted = 1'b1;
    // First cycle out of reset fetches the stored image
    if (!st.booted)
    begin
      next_st.load_req = 1'b1;
    end
    if (reg_wr)
    begin
      if (route_hit)
      begin
        next_st.cfg.route[reg_off] = reg_wdata[4:0];
      end
      else if (line_hit)
      begin
        next_st.cfg.inv[reg_off] = reg_wdata[ISM_LINE_INV_BIT];
        next_st.cfg.frc[reg_off] = reg_wdata[ISM_LINE_FRC_BIT];
      end
      else if (reg_addr == ISM_CMD_ADDR)
      begin
        if (reg_wdata[ISM_CMD_SAVE_BIT])
        begin
          next_st.save = 1'b1;
          next_st.nv_wdata = st.cfg;
        end
        if (reg_wdata[ISM_CMD_LOAD_BIT])
        begin
          next_st.load_req = 1'b1;
        end
      end
    end
    // A returning image overrides a same-cycle register write
    if (nv_rdata_valid)
    begin
      next_st.cfg = nv_rdata;
    end
    // Restoring defaults has the last word
    if (reg_wr && (reg_addr == ISM_CMD_ADDR)
      && reg_wdata[ISM_CMD_DEFAULT_BIT])
    begin
      next_st.cfg = ISM_IMAGE_DEFAULT;
    end
    if (reg_rd)
    begin
      if (route_hit)
      begin
        next_st.rdata = 32'(st.cfg.route[reg_off]);
      end
      else if (line_hit)
      begin
        next_st.rdata[ISM_LINE_INV_BIT] = st.cfg.inv[reg_off];
        next_st.rdata[ISM_LINE_FRC_BIT] = st.cfg.frc[reg_off];
      end
      else if (reg_addr == ISM_SRC_STAT_ADDR)
      begin
        next_st.rdata = 32'(src_vec);
      end
      else if (reg_addr == ISM_SINK_STAT_ADDR)
      begin
        next_st.rdata = 32'(st.sink);
      end
      else if (reg_addr == ISM_PIN_STAT_ADDR)
      begin
        next_st.rdata = 32'(od_sync);
      end
    end
    next_st.sink = sink_cond;
    // Open-drain switch conducts while its line is high
    next_st.od_oe = sink_cond[ISM_NOD-1:0];
    next_st.od_out = '0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st <= ISM_STATE_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign sink_out = st.sink;
  assign od_out = st.od_out;
  assign od_oe = st.od_oe;
  assign nv_save = st.save;
  assign nv_load_req = st.load_req;
  assign nv_wdata = st.nv_wdata;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  function automatic logic line_clear(input logic [4:0] line);
    line_clear = !st.cfg.inv[line] && !st.cfg.frc[line];
  endfunction

  sequence deb_from_pin0;
    st.cfg.route[ISM_SINK_DEBOUNCE] == ISM_SRC_PIN0
      && line_clear(ISM_SINK_LINE[ISM_SINK_DEBOUNCE])
      && line_clear(5'(ISM_LINE_INPUT0));
  endsequence

  sequence quiet_cfg;
    !reg_wr && !nv_rdata_valid;
  endsequence

  route_write_a: assert property (
    reg_wr && route_hit && !nv_rdata_valid
      && !(reg_addr == ISM_CMD_ADDR)
    |=> st.cfg.route[$past(reg_off)] == $past(reg_wdata[4:0]))
    else $error("route select not taken on next edge");

  any_route_a: assert property (
    st.cfg.route[ISM_SINK_TRIGGER] < 5'(ISM_NSRC)
      && line_clear(ISM_SINK_LINE[ISM_SINK_TRIGGER])
    |=> sink_out[ISM_SINK_TRIGGER]
      == $past(src_vec[st.cfg.route[ISM_SINK_TRIGGER]]))
    else $error("trigger sink does not follow its source");

  logic_loop_a: assert property (
    st.cfg.route[ISM_SINK_LOGIC_A] == ISM_SRC_LOGIC
      && line_clear(ISM_SINK_LINE[ISM_SINK_LOGIC_A])
    |=> sink_out[ISM_SINK_LOGIC_A] == $past(int_src.logic_res))
    else $error("logic result not routed to logic input");

  od_drive_a: assert property (
    od_oe == $past(sink_cond[ISM_NOD-1:0]) && od_out == '0
      && od_oe == sink_out[ISM_NOD-1:0])
    else $error("open-drain pins disagree with their sinks");

  strobe_return_a: assert property (
    st.cfg.route[ISM_SINK_PULSE0] == ISM_SRC_STROBE2
      && line_clear(ISM_SINK_LINE[ISM_SINK_PULSE0])
    |=> sink_out[ISM_SINK_PULSE0] == $past(int_src.strobe[2]))
    else $error("strobe 2 not offered at its source");

  seq_active_a: assert property (
    st.cfg.route[ISM_SINK_SEQ] == ISM_SRC_SEQ_ACTIVE
      && line_clear(ISM_SINK_LINE[ISM_SINK_SEQ])
    |=> sink_out[ISM_SINK_SEQ] == $past(int_src.seq_active))
    else $error("sequencer active flag misrouted");

  deb_path_a: assert property (
    deb_from_pin0 ##2 deb_from_pin0
    |=> sink_out[ISM_SINK_DEBOUNCE] == $past(pin_in.trig_in[0], 3))
    else $error("pin to debouncer path not three cycles");

  prescale_a: assert property (
    st.cfg.route[ISM_SINK_PRESCALE] == ISM_SRC_PRESCALED
      && line_clear(ISM_SINK_LINE[ISM_SINK_PRESCALE])
    |=> sink_out[ISM_SINK_PRESCALE] == $past(int_src.prescaled))
    else $error("prescaled signal misrouted");

  line_map_a: assert property (
    st.cfg.route[ISM_SINK_LOGIC_A] == ISM_SRC_DEBOUNCED
      && st.cfg.inv[ISM_SINK_LINE[ISM_SINK_LOGIC_A]]
      && !st.cfg.frc[ISM_SINK_LINE[ISM_SINK_LOGIC_A]]
    |=> sink_out[ISM_SINK_LOGIC_A] == !$past(int_src.debounced))
    else $error("logic A line inverter misapplied");

  invert_a: assert property (
    st.cfg.route[ISM_SINK_UART2_RXD] == ISM_SRC_UART2_TXD
      && st.cfg.inv[ISM_SINK_LINE[ISM_SINK_UART2_RXD]]
      && !st.cfg.frc[ISM_SINK_LINE[ISM_SINK_UART2_RXD]]
    |=> sink_out[ISM_SINK_UART2_RXD] != $past(int_src.uart2_txd))
    else $error("inverted line passes true signal");

  force_high_a: assert property (
    st.cfg.frc[ISM_SINK_LINE[ISM_SINK_TRIGGER]]
      && !st.cfg.inv[ISM_SINK_LINE[ISM_SINK_TRIGGER]]
    |=> sink_out[ISM_SINK_TRIGGER])
    else $error("forced line not high");

  force_low_a: assert property (
    (st.cfg.frc[ISM_SINK_LINE[ISM_SINK_SEQ]]
      && st.cfg.inv[ISM_SINK_LINE[ISM_SINK_SEQ]]) ##0 quiet_cfg [*2]
    |=> !sink_out[ISM_SINK_SEQ][*2])
    else $error("forced inverted line not low");

  save_image_a: assert property (
    reg_wr && reg_addr == ISM_CMD_ADDR && reg_wdata[ISM_CMD_SAVE_BIT]
    |=> nv_save && nv_wdata == $past(st.cfg) ##1 !nv_save)
    else $error("save command pulse or image wrong");

  boot_load_a: assert property (
    $fell(rst) |=> nv_load_req ##1 !nv_load_req)
    else $error("no single load request after reset");

  restore_a: assert property (
    reg_wr && reg_addr == ISM_CMD_ADDR && reg_wdata[ISM_CMD_DEFAULT_BIT]
    |=> st.cfg == ISM_IMAGE_DEFAULT ##1 sink_out == '0)
    else $error("defaults not restored");

  read_timing_a: assert property (
    reg_rd && route_hit |=> reg_rdata == 32'($past(st.cfg.route[reg_off]))
      ##1 (reg_rdata == '0 || $past(reg_rd)))
    else $error("read data not in the following cycle only");

  // Unmapped writes must leave the whole image alone
  unmapped_write_a: assert property (
    reg_wr && !route_hit && !line_hit && reg_addr != ISM_CMD_ADDR
      && !nv_rdata_valid
    |=> st.cfg == $past(st.cfg))
    else $error("unmapped write changed the routing image");

  line_write_a: assert property (
    reg_wr && line_hit && !nv_rdata_valid
    |=> st.cfg.inv[$past(reg_off)] == $past(reg_wdata[ISM_LINE_INV_BIT])
      && st.cfg.frc[$past(reg_off)] == $past(reg_wdata[ISM_LINE_FRC_BIT]))
    else $error("line config not taken on next edge");

  image_load_a: assert property (
    nv_rdata_valid && !(reg_wr && reg_addr == ISM_CMD_ADDR
      && reg_wdata[ISM_CMD_DEFAULT_BIT])
    |=> st.cfg == $past(nv_rdata))
    else $error("returned image not taken");

  src_status_a: assert property (
    reg_rd && reg_addr == ISM_SRC_STAT_ADDR
    |=> reg_rdata == 32'($past(src_vec)))
    else $error("source status read wrong");

  sink_status_a: assert property (
    reg_rd && reg_addr == ISM_SINK_STAT_ADDR
    |=> reg_rdata == 32'($past(sink_out)))
    else $error("sink status read wrong");

  // Forcing input line 10 high must set pin source 0 high ahead of the sink selectors
  input_force_a: assert property (
    st.cfg.frc[ISM_LINE_INPUT0] && !st.cfg.inv[ISM_LINE_INPUT0]
    |-> src_vec[ISM_SRC_PIN0])
    else $error("forced input line not high");

endmodule

// file: verification/ism_io_partner.sv
module ism_io_partner
  import ism_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] trig,
  input wire logic rxd,
  input wire logic aux_rxd,
  output ism_pin_in_t pin_in,
  input wire logic [ISM_NOD-1:0] od_oe,
  output logic [ISM_NOD-1:0] od_in,
  input wire logic nv_save,
  input wire ism_image_t nv_wdata,
  input wire logic nv_load_req,
  output ism_image_t nv_rdata,
  output logic nv_rdata_valid
);
  timeunit 1ns;
  timeprecision 1ns;

  // Store content survives reset, as a non-volatile part would
  ism_image_t mem = ISM_IMAGE_DEFAULT;
  logic [2:0] dly = '0;
  logic vld = 1'b0;

  assign pin_in = '{trig_in: trig, rxd: rxd, aux_rxd: aux_rxd};
  // Pull-up on each open-drain wire; an enabled switch pulls it low
  assign od_in = ~od_oe;
  // Outside an answer the data lines carry garbage, never the image
  assign nv_rdata = vld ? mem : ~mem;
  assign nv_rdata_valid = vld;

  always @(posedge sys_clk)
  begin
    vld <= 1'b0;
    if (rst)
    begin
      dly <= '0;
    end
    else
    begin
      if (nv_save)
      begin
        mem <= nv_wdata;
      end
      if (nv_load_req)
      begin
        dly <= 3'h3;
      end
      else if (dly != 3'h0)
      begin
        dly <= dly - 3'h1;
        vld <= (dly == 3'h1);
      end
    end
  end
endmodule

// file: verification/ism_switch_matrix_tb.sv
module ism_switch_matrix_tb
  import ism_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TK [18] = '{10, 11, 7, 8, 9, 13, 14, 15, 16, 6, 12, 17, 4,
    5, 0, 1, 2, 3};
  localparam int TS [18] = '{19, 16, 15, 0, 17, 6, 7, 20, 21, 12, 18, 24,
    23, 5, 8, 9, 13, 14};

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  ism_pin_in_t pin_in;
  logic [ISM_NOD-1:0] od_in, od_out, od_oe;
  ism_int_src_t isrc = '0;
  logic [ISM_NSINK-1:0] sink_out;
  logic nv_save, nv_load_req, nv_rdata_valid;
  ism_image_t nv_wdata, nv_rdata;
  ism_image_t sh = ISM_IMAGE_DEFAULT;
  ism_image_t saved;
  logic [3:0] trig = '0;
  logic rxd = 1'b0;
  logic aux = 1'b0;
  int err_count = 0;
  int checks_done = 0;
  int seed = 32'h66f5;
  logic [31:0] rd;

  initial forever #50 sys_clk = ~sys_clk;

  ism_switch_matrix u_dut (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .od_in(od_in),
    .int_src(isrc), .sink_out(sink_out), .od_out(od_out), .od_oe(od_oe),
    .nv_save(nv_save), .nv_load_req(nv_load_req), .nv_wdata(nv_wdata),
    .nv_rdata(nv_rdata), .nv_rdata_valid(nv_rdata_valid));

  ism_io_partner u_far (.sys_clk(sys_clk), .rst(rst), .trig(trig),
    .rxd(rxd), .aux_rxd(aux), .pin_in(pin_in), .od_oe(od_oe),
    .od_in(od_in), .nv_save(nv_save), .nv_wdata(nv_wdata),
    .nv_load_req(nv_load_req), .nv_rdata(nv_rdata),
    .nv_rdata_valid(nv_rdata_valid));

  function automatic logic cond(logic s, logic iv, logic f);
    return f ? ~iv : s ^ iv;
  endfunction

  function automatic logic src_val(int s);
    logic [24:0] v;
    v = {isrc.uart2_txd, isrc.trig_feedback, aux, isrc.strobe[3],
      isrc.strobe[2], isrc.logic_res, isrc.seq_mask, isrc.prescaled,
      isrc.debounced, isrc.seq_active, isrc.seq_mod[3], isrc.seq_mod[2],
      isrc.seq_pulse, isrc.readout, isrc.expose, isrc.seq_mod[1],
      isrc.seq_mod[0], isrc.strobe[1], isrc.strobe[0], isrc.uart1_txd,
      rxd, trig};
    // Input lines condition pin sources 0 to 4 before they are routed
    if (s > 24)
      return 1'b0;
    return s < 5 ? cond(v[s], sh.inv[10+s], sh.frc[10+s]) : v[s];
  endfunction

  function automatic logic exp_sink(int k);
    int l;
    l = int'(ISM_SINK_LINE[k]);
    return cond(src_val(int'(sh.route[k])), sh.inv[l], sh.frc[l]);
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string n, input logic [135:0] e,
    input logic [135:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic br(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  task automatic set_route(input int k, input int s);
    sh.route[k] = s[4:0];
    bw(ISM_ROUTE_BASE + 8'(k), 32'(s[4:0]));
  endtask

  task automatic set_line(input int l, input logic iv, input logic f);
    sh.inv[l] = iv;
    sh.frc[l] = f;
    bw(ISM_LINE_BASE + 8'(l), {30'h0, f, iv});
  endtask

  task automatic do_reset();
    int n;
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (n = 0; n < 5; n++)
    begin
      cyc(1);
      if (nv_load_req === 1'b1)
        break;
    end
    if (n == 5)
    begin
      err_count++;
      $display("[ERR] boot_load expected 1 seen 0");
      final_report();
    end
    cyc(8);
  endtask

  task automatic run_case(input int k, input int s, input logic [1:0] c);
    logic [31:0] r;
    r = $random(seed);
    @(posedge sys_clk);
    isrc <= ism_int_src_t'(r[18:0]);
    trig <= r[25:22];
    rxd <= r[26];
    aux <= r[27];
    set_route(k, s);
    set_line(int'(ISM_SINK_LINE[k]), c[0], c[1]);
    if (s < 5)
      set_line(10 + s, r[28], r[29]);
    // Pin sources need two sync stages before the sink register
    cyc(6);
    chk("sink", 136'(exp_sink(k)), 136'(sink_out[k]));
    if (k < 4)
    begin
      chk("od_oe", 136'(exp_sink(k)), 136'(od_oe[k]));
      chk("od_out", 136'h0, 136'(od_out));
      br(ISM_PIN_STAT_ADDR);
      chk("od_wire", 136'(!exp_sink(k)), 136'(rd[k]));
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("[ERR] run_time expected done seen hang");
    final_report();
  end

  initial
  begin
    do_reset();
    chk("sink_rst", 136'h0, 136'(sink_out));
    br(ISM_ROUTE_BASE);
    chk("route_rst", 136'h1F, 136'(rd));
    for (int i = 0; i < 18; i++)
      for (int j = 0; j < 4; j++)
        run_case(TK[i], TS[i], 2'(j));
    $display("test fixed routes done");
    for (int i = 0; i < 40; i++)
      run_case({$random(seed)} % 18, {$random(seed)} % 25,
        2'($random(seed)));
    $display("test random routes done");
    set_route(6, 19);
    set_line(6, 1'b0, 1'b0);
    @(posedge sys_clk);
    isrc <= '0;
    repeat (3) @(posedge sys_clk);
    isrc.logic_res <= 1'b1;
    #1;
    chk("sink_early", 136'h0, 136'(sink_out[6]));
    cyc(1);
    chk("sink_next", 136'h1, 136'(sink_out[6]));
    br(ISM_ROUTE_BASE + 8'h06);
    chk("route_read", 136'h13, 136'(rd));
    cyc(1);
    chk("rdata_drop", 136'h0, 136'(reg_rdata));
    bw(8'h12, 32'h5);
    br(8'h12);
    chk("unmapped_route", 136'h0, 136'(rd));
    br(8'h37);
    chk("unmapped_line", 136'h0, 136'(rd));
    br(ISM_CMD_ADDR);
    chk("cmd_read", 136'h0, 136'(rd));
    br(ISM_SINK_STAT_ADDR);
    chk("sink_stat", 136'h1, 136'(rd[6]));
    br(ISM_SRC_STAT_ADDR);
    chk("src_stat", 136'h1, 136'(rd[19]));
    $display("test timing and registers done");
    for (int i = 0; i < 23; i++)
      set_line(i, 1'($random(seed)), 1'($random(seed)));
    for (int i = 0; i < 23; i++)
    begin
      br(ISM_LINE_BASE + 8'(i));
      chk("line_cfg", 136'({sh.frc[i], sh.inv[i]}), 136'(rd));
    end
    $display("test line index done");
    set_route(0, 5);
    set_route(17, 24);
    saved = sh;
    bw(ISM_CMD_ADDR, 32'h1);
    #1;
    chk("nv_save", 136'h1, 136'(nv_save));
    chk("nv_wdata", saved, nv_wdata);
    cyc(1);
    chk("nv_save_end", 136'h0, 136'(nv_save));
    bw(ISM_CMD_ADDR, 32'h4);
    sh = ISM_IMAGE_DEFAULT;
    br(ISM_ROUTE_BASE + 8'h11);
    chk("route_default", 136'h1F, 136'(rd));
    bw(ISM_CMD_ADDR, 32'h2);
    #1;
    chk("nv_load_req", 136'h1, 136'(nv_load_req));
    cyc(6);
    sh = saved;
    br(ISM_ROUTE_BASE);
    chk("route_loaded", 136'h5, 136'(rd));
    do_reset();
    br(ISM_ROUTE_BASE + 8'h11);
    chk("route_boot", 136'h18, 136'(rd));
    chk("sink_boot", 136'(exp_sink(17)), 136'(sink_out[17]));
    $display("test store and defaults done");
    final_report();
  end
endmodule
